// ==== core/macx_pkg.sv ====
// macx_pkg: shared constants for the mmu access control extension block
package macx_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] AUXC_OFS    = 8'h04;
  localparam logic [7:0] PRIREMAP_OFS = 8'h08;
  localparam logic [7:0] NRMREMAP_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS  = 8'h10;
  localparam logic [7:0] MASK_OFS    = 8'h14;
  localparam logic [7:0] DFAULT_OFS  = 8'h18;
  localparam logic [7:0] IFAULT_OFS  = 8'h1C;
  // control register fields
  localparam int REMAP_EN_BIT   = 28;
  localparam int ACC_FLAG_EN_BIT = 29;
  // aux control: cache-size limit flag position
  localparam int CSZ_LIMIT_BIT = 6;
  // control register: deprecated system and rom protect bits
  localparam int SYS_PROT_BIT  = 8;
  localparam int ROM_PROT_BIT  = 9;
  // descriptor field positions
  localparam int DESC_B_BIT    = 2;
  localparam int DESC_C_BIT    = 3;
  localparam int DESC_AP_LSB   = 10;
  localparam int DESC_TEX_LSB  = 12;
  localparam int DESC_APX_BIT  = 15;
  // reset values
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] AUXC_RST     = 32'h0000_0000;
  localparam logic [31:0] PRIREMAP_RST = 32'h0000_0000;
  localparam logic [31:0] NRMREMAP_RST = 32'h0000_0000;
  // cache capacities in KB
  localparam logic [7:0] CACHE_LIMIT_KB = 8'h10;
  // fault status codes (5-bit status field)
  localparam logic [4:0] FS_NONE       = 5'h00;
  localparam logic [4:0] FS_AFLAG_SECT = 5'h03;
  localparam logic [4:0] FS_AFLAG_PAGE = 5'h06;
  localparam logic [4:0] FS_PERM_SECT  = 5'h0D;
  localparam logic [4:0] FS_PERM_PAGE  = 5'h0F;
  // status / interrupt bits
  localparam int EV_DFAULT = 0;
  localparam int EV_IFAULT = 1;
  localparam int EV_COUNT  = 2;
  // memory types
  typedef enum logic [1:0]
  {
    MT_STRONG = 2'b00,
    MT_DEVICE = 2'b01,
    MT_NORMAL = 2'b10,
    MT_RSVD   = 2'b11
  } macx_mtype_type;
endpackage : macx_pkg

// ==== core/macx_perm.sv ====
// macx_perm: permission and access flag check for one access
`timescale 1ns/10ps
`default_nettype none
module macx_perm
  import macx_pkg::*;
(
  // control protect bits and descriptor fields
  input  wire logic       sysProt,
  input  wire logic       romProt,
  input  wire logic       permission_extension_bit,
  input  wire logic [1:0] permission_field,
  input  wire logic       isSection,
  // access
  input  wire logic       userMode,
  input  wire logic       isWrite,
  input  wire logic       access_flag_enable,
  // result
  output logic            faultHit,
  output logic [4:0]      faultCode
);
  logic [1:0] apEff;
  logic       afClear;
  logic       permOk;

  // with the flag enabled bit 0 no longer selects permission
  assign apEff   = access_flag_enable ? {permission_field[1], 1'b1} : permission_field;
  assign afClear = access_flag_enable & ~permission_field[0];

  always_comb
  begin
    permOk = 1'b0;
    unique case ({permission_extension_bit, apEff})
      3'b000: permOk = ~sysProt & ~romProt ? 1'b0 : (~isWrite & (romProt | ~userMode));
      3'b001: permOk = ~userMode;
      3'b010: permOk = ~userMode | ~isWrite;
      3'b011: permOk = 1'b1;
      3'b101: permOk = ~userMode & ~isWrite;
      3'b110: permOk = ~isWrite;
      3'b111: permOk = (~sysProt & ~romProt) & ~isWrite;
      default: permOk = 1'b0;
    endcase
  end

  // access flag fault takes priority over permission fault
  assign faultHit  = afClear | ~permOk;
  assign faultCode = afClear ? (isSection ? FS_AFLAG_SECT : FS_AFLAG_PAGE)
                   : (~permOk ? (isSection ? FS_PERM_SECT : FS_PERM_PAGE) : FS_NONE);
endmodule : macx_perm
`default_nettype wire

// ==== core/macx_attr.sv ====
// macx_attr: memory attribute derivation, direct or remapped
`timescale 1ns/10ps
`default_nettype none
module macx_attr
  import macx_pkg::*;
(
  // descriptor fields
  input  wire logic [2:0]  type_extension_field,
  input  wire logic        cacheBit,
  input  wire logic        bufferBit,
  // remap control
  input  wire logic        remap_enable,
  input  wire logic [31:0] primary_region_remap_register,
  input  wire logic [31:0] normal_memory_remap_register,
  // attributes
  output macx_pkg::macx_mtype_type memType,
  output logic [1:0]       innerAttr,
  output logic [1:0]       outerAttr
);
  logic [2:0] regionIdx;
  logic [1:0] remapType;
  logic [1:0] remapInner;
  logic [1:0] remapOuter;
  logic       directNormal;

  // tex[2:1] unused while remapping so software may keep own bits there
  assign regionIdx  = {type_extension_field[0], cacheBit, bufferBit};
  assign remapType  = primary_region_remap_register[{regionIdx, 1'b0} +: 2];
  assign remapInner = normal_memory_remap_register[{regionIdx, 1'b0} +: 2];
  assign remapOuter = normal_memory_remap_register[{1'b1, regionIdx, 1'b0} +: 2];

  assign directNormal = type_extension_field[2];

  always_comb
  begin
    memType   = MT_STRONG;
    innerAttr = 2'b00;
    outerAttr = 2'b00;
    if (remap_enable)
    begin
      memType   = macx_mtype_type'(remapType);
      innerAttr = remapInner;
      outerAttr = remapOuter;
    end
    else if (directNormal)
    begin
      memType   = MT_NORMAL;
      innerAttr = {cacheBit, bufferBit};
      outerAttr = type_extension_field[1:0];
    end
    else
    begin
      unique case ({type_extension_field[1:0], cacheBit, bufferBit})
        4'b0000: memType = MT_STRONG;
        4'b0001: memType = MT_DEVICE;
        4'b0010:
        begin
          memType   = MT_NORMAL;
          innerAttr = 2'b10;
          outerAttr = 2'b10;
        end
        4'b0011:
        begin
          memType   = MT_NORMAL;
          innerAttr = 2'b11;
          outerAttr = 2'b11;
        end
        4'b0100: memType = MT_NORMAL;
        4'b0111:
        begin
          memType   = MT_NORMAL;
          innerAttr = 2'b01;
          outerAttr = 2'b01;
        end
        4'b1000: memType = MT_DEVICE;
        default: memType = MT_RSVD;
      endcase
    end
  end
endmodule : macx_attr
`default_nettype wire

// ==== core/macx_top.sv ====
// macx_top: mmu access control extension with apb registers
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - limit flag caps each cache at 16KB
// - apx=1 ap=11 s=r=0 read-only everyone
// - ap bit 0 is access flag, software-managed
// - access flag only while control bit 29
// - clear access flag aborts access when enabled
// - fault status uses dedicated access flag codes
// - no remap: attributes from tex, c, b
// - remap only while control bit 28 set
// - remap ignores tex bits 2 and 1
// - remap attributes from two remap registers
module macx_top
  import macx_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // data access request
  input  wire logic        dReq,
  input  wire logic        dWrite,
  input  wire logic        dUser,
  input  wire logic [31:0] dDesc,
  input  wire logic        dSection,
  // instruction access request
  input  wire logic        iReq,
  input  wire logic        iUser,
  input  wire logic [31:0] iDesc,
  input  wire logic        iSection,
  // data access result
  output logic             dValid,
  output logic             dAbort,
  output macx_pkg::macx_mtype_type dMemType,
  output logic [1:0]       dInner,
  output logic [1:0]       dOuter,
  // instruction access result
  output logic             iValid,
  output logic             iAbort,
  output macx_pkg::macx_mtype_type iMemType,
  output logic [1:0]       iInner,
  output logic [1:0]       iOuter,
  // cache sizing and interrupt
  output logic             cacheLimit,
  output logic [7:0]       cacheLimitKb,
  output logic             irq
);
  logic [31:0] ctrl_q;
  logic [31:0] auxc_q;
  logic [31:0] priRemap_q;
  logic [31:0] nrmRemap_q;
  logic [EV_COUNT-1:0] status_q;
  logic [EV_COUNT-1:0] mask_q;
  logic [4:0]  data_fault_status_register_q;
  logic [4:0]  instruction_fault_status_register_q;
  logic [31:0] prdata_q;
  logic        dValid_q;
  logic        dAbort_q;
  logic        iValid_q;
  logic        iAbort_q;
  logic [1:0]  dMemType_q;
  logic [1:0]  iMemType_q;
  logic [1:0]  dInner_q;
  logic [1:0]  dOuter_q;
  logic [1:0]  iInner_q;
  logic [1:0]  iOuter_q;

  // system and rom protect are deprecated but still decoded, so old
  // tables keep their meaning
  wire accFlagEn = ctrl_q[ACC_FLAG_EN_BIT];
  wire remapEn   = ctrl_q[REMAP_EN_BIT];
  wire sysProt   = ctrl_q[SYS_PROT_BIT];
  wire romProt   = ctrl_q[ROM_PROT_BIT];

  // descriptor fields, data port
  wire       dApx   = dDesc[DESC_APX_BIT];
  wire [1:0] dAp    = dDesc[DESC_AP_LSB +: 2];
  wire [2:0] dTex   = dDesc[DESC_TEX_LSB +: 3];
  wire       dCache = dDesc[DESC_C_BIT];
  wire       dBuf   = dDesc[DESC_B_BIT];

  // descriptor fields, fetch port
  wire       iApx   = iDesc[DESC_APX_BIT];
  wire [1:0] iAp    = iDesc[DESC_AP_LSB +: 2];
  wire [2:0] iTex   = iDesc[DESC_TEX_LSB +: 3];
  wire       iCache = iDesc[DESC_C_BIT];
  wire       iBuf   = iDesc[DESC_B_BIT];

  // apb decode
  wire apbAccess = psel & penable;
  wire apbWr     = apbAccess & pwrite;
  wire apbRd     = apbAccess & ~pwrite;
  wire apbSetup  = psel & ~penable;
  wire rdSetup   = apbSetup & ~pwrite;
  wire hitCtrl   = paddr == CTRL_OFS;
  wire hitAuxc   = paddr == AUXC_OFS;
  wire hitPri    = paddr == PRIREMAP_OFS;
  wire hitNrm    = paddr == NRMREMAP_OFS;
  wire hitStat   = paddr == STATUS_OFS;
  wire hitMask   = paddr == MASK_OFS;
  wire hitDfs    = paddr == DFAULT_OFS;
  wire hitIfs    = paddr == IFAULT_OFS;
  wire hitAny    = hitCtrl | hitAuxc | hitPri | hitNrm | hitStat | hitMask | hitDfs | hitIfs;

  // write strobes
  wire wrCtrl    = apbWr & hitCtrl;
  wire wrAuxc    = apbWr & hitAuxc;
  wire wrPri     = apbWr & hitPri;
  wire wrNrm     = apbWr & hitNrm;
  wire wrMask    = apbWr & hitMask;
  wire wrDfs     = apbWr & hitDfs;
  wire wrIfs     = apbWr & hitIfs;

  wire [31:0] rdMux =
      hitCtrl ? ctrl_q :
      hitAuxc ? auxc_q :
      hitPri  ? priRemap_q :
      hitNrm  ? nrmRemap_q :
      hitStat ? {30'h0000_0000, status_q} :
      hitMask ? {30'h0000_0000, mask_q} :
      hitDfs  ? {27'h000_0000, data_fault_status_register_q} :
      hitIfs  ? {27'h000_0000, instruction_fault_status_register_q} : 32'h0000_0000;

  // zero wait states: read data already stands in the access phase
  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~hitAny;
  assign prdata  = prdata_q;

  // per-port checks
  wire       dFault;
  wire [4:0] dCode;
  wire       iFault;
  wire [4:0] iCode;
  macx_mtype_type dType;
  macx_mtype_type iType;
  logic [1:0] dIn;
  logic [1:0] dOut;
  logic [1:0] iIn;
  logic [1:0] iOut;

  macx_perm uDPerm (
    .sysProt                  (sysProt),
    .romProt                  (romProt),
    .permission_extension_bit (dApx),
    .permission_field         (dAp),
    .isSection                (dSection),
    .userMode                 (dUser),
    .isWrite                  (dWrite),
    .access_flag_enable       (accFlagEn),
    .faultHit                 (dFault),
    .faultCode                (dCode)
  );

  macx_perm uIPerm (
    .sysProt                  (sysProt),
    .romProt                  (romProt),
    .permission_extension_bit (iApx),
    .permission_field         (iAp),
    .isSection                (iSection),
    .userMode                 (iUser),
    .isWrite                  (1'b0),
    .access_flag_enable       (accFlagEn),
    .faultHit                 (iFault),
    .faultCode                (iCode)
  );

  macx_attr uDAttr (
    .type_extension_field          (dTex),
    .cacheBit                      (dCache),
    .bufferBit                     (dBuf),
    .remap_enable                  (remapEn),
    .primary_region_remap_register (priRemap_q),
    .normal_memory_remap_register  (nrmRemap_q),
    .memType                       (dType),
    .innerAttr                     (dIn),
    .outerAttr                     (dOut)
  );

  macx_attr uIAttr (
    .type_extension_field          (iTex),
    .cacheBit                      (iCache),
    .bufferBit                     (iBuf),
    .remap_enable                  (remapEn),
    .primary_region_remap_register (priRemap_q),
    .normal_memory_remap_register  (nrmRemap_q),
    .memType                       (iType),
    .innerAttr                     (iIn),
    .outerAttr                     (iOut)
  );

  // fault events; hardware set beats read clear
  wire dEv = dReq & dFault;
  wire iEv = iReq & iFault;
  wire [EV_COUNT-1:0] evVec = {iEv, dEv};
  wire statRdClr = apbRd & hitStat;
  wire [EV_COUNT-1:0] status_d;

  // a read clears only the bits it returned, so a fault that lands
  // between the setup and access edges survives for the next read
  for (genvar ev = 0; ev < EV_COUNT; ev++)
  begin : g_status
    wire clrBit = statRdClr & prdata_q[ev];
    assign status_d[ev] = evVec[ev] | (status_q[ev] & ~clrBit);
  end

  // configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_q     <= CTRL_RST;
      auxc_q     <= AUXC_RST;
      priRemap_q <= PRIREMAP_RST;
      nrmRemap_q <= NRMREMAP_RST;
      mask_q     <= {EV_COUNT{1'b0}};
    end
    else if (clkEn)
    begin
      if (wrCtrl)
        ctrl_q <= pwdata;
      if (wrAuxc)
        auxc_q <= pwdata;
      if (wrPri)
        priRemap_q <= pwdata;
      if (wrNrm)
        nrmRemap_q <= pwdata;
      if (wrMask)
        mask_q <= pwdata[EV_COUNT-1:0];
    end
  end

  // sticky fault status
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      status_q <= {EV_COUNT{1'b0}};
    else if (clkEn)
      status_q <= status_d;
  end

  // read data is taken in the setup phase so it already stands when
  // pready is sampled; one cycle stale, but no wait state needed
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prdata_q <= 32'h0000_0000;
    else if (clkEn && rdSetup)
      prdata_q <= rdMux;
  end

  // data fault status, a new fault beats a software write
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      data_fault_status_register_q <= FS_NONE;
    else if (clkEn)
    begin
      if (dEv)
        data_fault_status_register_q <= dCode;
      else if (wrDfs)
        data_fault_status_register_q <= pwdata[4:0];
    end
  end

  // fetch fault status, same priority
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      instruction_fault_status_register_q <= FS_NONE;
    else if (clkEn)
    begin
      if (iEv)
        instruction_fault_status_register_q <= iCode;
      else if (wrIfs)
        instruction_fault_status_register_q <= pwdata[4:0];
    end
  end

  // data results, one cycle after request
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dValid_q   <= 1'b0;
      dAbort_q   <= 1'b0;
      dMemType_q <= 2'b00;
      dInner_q   <= 2'b00;
      dOuter_q   <= 2'b00;
    end
    else if (clkEn)
    begin
      dValid_q   <= dReq;
      dAbort_q   <= dEv;
      dMemType_q <= dType;
      dInner_q   <= dIn;
      dOuter_q   <= dOut;
    end
  end

  // fetch results, same timing as data
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      iValid_q   <= 1'b0;
      iAbort_q   <= 1'b0;
      iMemType_q <= 2'b00;
      iInner_q   <= 2'b00;
      iOuter_q   <= 2'b00;
    end
    else if (clkEn)
    begin
      iValid_q   <= iReq;
      iAbort_q   <= iEv;
      iMemType_q <= iType;
      iInner_q   <= iIn;
      iOuter_q   <= iOut;
    end
  end

  assign dValid   = dValid_q;
  assign dAbort   = dAbort_q;
  assign iValid   = iValid_q;
  assign iAbort   = iAbort_q;
  assign dMemType = macx_mtype_type'(dMemType_q);
  assign iMemType = macx_mtype_type'(iMemType_q);
  assign dInner   = dInner_q;
  assign dOuter   = dOuter_q;
  assign iInner   = iInner_q;
  assign iOuter   = iOuter_q;

  // capacity cap lets aliases ignore colour bits at a performance cost
  assign cacheLimit   = auxc_q[CSZ_LIMIT_BIT];
  assign cacheLimitKb = CACHE_LIMIT_KB;
  assign irq = |(status_q & mask_q);
endmodule : macx_top
`default_nettype wire

// ==== verif/macx_monitor.sv ====
// macx_monitor: port-level assertions for macx_top
`timescale 1ns/10ps
`default_nettype none
module macx_monitor
  import macx_pkg::*;
(
  // clock, reset, apb
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // accesses and results
  input wire logic        dReq,
  input wire logic        dWrite,
  input wire logic        dUser,
  input wire logic [31:0] dDesc,
  input wire logic        iReq,
  input wire logic [31:0] iDesc,
  input wire logic        dValid,
  input wire logic        dAbort,
  input wire macx_pkg::macx_mtype_type dMemType,
  input wire logic [1:0]  dInner,
  input wire logic [1:0]  dOuter,
  input wire logic        iValid,
  input wire logic        iAbort,
  input wire logic        cacheLimit,
  input wire logic [7:0]  cacheLimitKb
);
  logic [31:0] ctrl_q, aux_q, pri_q, nrm_q;
  wire wrTake = psel && penable && pwrite && clkEn;
  wire mapped = paddr[1:0] == 2'h0 && paddr <= 8'h1C;
  wire dTake = dReq && clkEn;
  wire [2:0] idx = {dDesc[12], dDesc[3], dDesc[2]};
  wire [1:0] remType = pri_q[{idx, 1'b0} +: 2];
  wire [1:0] remIn = nrm_q[{idx, 1'b0} +: 2];
  wire [1:0] remOut = nrm_q[{1'b1, idx, 1'b0} +: 2];
  // shadow copies from observed writes, so no peeking inside the design
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_q <= 32'h0;
      aux_q <= 32'h0;
      pri_q <= 32'h0;
      nrm_q <= 32'h0;
    end
    else if (wrTake)
    begin
      if (paddr == CTRL_OFS) ctrl_q <= pwdata;
      if (paddr == AUXC_OFS) aux_q <= pwdata;
      if (paddr == PRIREMAP_OFS) pri_q <= pwdata;
      if (paddr == NRMREMAP_OFS) nrm_q <= pwdata;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr wrong");
  a_dabort_valid: assert property (dAbort |-> dValid) else $error("data abort without valid");
  a_iabort_valid: assert property (iAbort |-> iValid) else $error("fetch abort without valid");
  a_limit_size: assert property (
    cacheLimit == aux_q[6] && cacheLimitKb == 8'h10) else $error("cache limit wrong");
  a_ro_both: assert property (
    dTake && !ctrl_q[8] && !ctrl_q[9] && dDesc[15] && dDesc[11:10] == 2'b11
    |=> dValid && dAbort == $past(dWrite)) else $error("read-only decode wrong");
  a_flag_dfault: assert property (
    dTake && ctrl_q[29] && !dDesc[10] |=> dAbort) else $error("no data flag abort");
  a_flag_ifault: assert property (
    iReq && clkEn && ctrl_q[29] && !iDesc[10] |=> iAbort) else $error("no fetch flag abort");
  a_flag_off: assert property (
    dTake && !ctrl_q[29] && !dDesc[15] && dDesc[11:10] == 2'b10 && !dUser |=> !dAbort)
    else $error("flag used while disabled");
  a_attr_direct: assert property (
    dTake && !ctrl_q[28] && dDesc[14] |=> dMemType == MT_NORMAL
    && dInner == $past(dDesc[3:2]) && dOuter == $past(dDesc[13:12]))
    else $error("direct attributes wrong");
  a_attr_remap: assert property (
    dTake && ctrl_q[28] |=> dMemType == $past(remType) && (dMemType != MT_NORMAL
    || dInner == $past(remIn) && dOuter == $past(remOut))) else $error("remap wrong");
endmodule : macx_monitor
bind macx_top macx_monitor macx_monitor_i (.*);
`default_nettype wire

// ==== verif/macx_top_test.sv ====
// macx_top_test: random self-checking bench for macx_top
`timescale 1ns/10ps
`default_nettype none
module macx_top_test;
  import macx_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic dReq = 1'b0, dWrite = 1'b0, dUser = 1'b0, dSection = 1'b0;
  logic iReq = 1'b0, iUser = 1'b0, iSection = 1'b0;
  logic [7:0] paddr = 8'h00, cacheLimitKb;
  logic [31:0] pwdata = 32'h0, dDesc = 32'h0, iDesc = 32'h0, prdata, rd, pri, nrm, desc;
  logic pready, pslverr, dValid, dAbort, iValid, iAbort, cacheLimit, irq;
  logic [1:0] dInner, dOuter, iInner, iOuter;
  logic [5:0] e;
  macx_mtype_type dMemType, iMemType;
  int error_cnt = 0, n_tests = 0, seed = 75, k;
  always #5 sys_clk = ~sys_clk;
  macx_top macx_top_i (.*);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // read data is taken at the edge that sees pready; the short wait
  // at the end only lets register outputs settle for the caller
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 9; k++)
    begin
      @(posedge sys_clk);
      rd = prdata;
      if (pready === 1'b1) break;
    end
    if (k == 9)
    begin
      error_cnt++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic acc(input logic ins, w, u, sec, input logic [31:0] dsc, input logic ab);
    @(posedge sys_clk);
    dReq <= !ins;
    iReq <= ins;
    dWrite <= w;
    dUser <= u;
    iUser <= u;
    dSection <= sec;
    iSection <= sec;
    dDesc <= dsc;
    iDesc <= dsc;
    @(posedge sys_clk);
    dReq <= 1'b0;
    iReq <= 1'b0;
    #1;
    chk("valid", ins ? iValid : dValid, 1'b1);
    chk("abort", ins ? iAbort : dAbort, ab);
  endtask : acc
  function automatic logic [5:0] remap_exp(input logic [31:0] pr, nm, dsc);
    int i;
    i = {dsc[12], dsc[3], dsc[2]};
    return {pr[2 * i +: 2], nm[2 * i +: 2], nm[16 + 2 * i +: 2]};
  endfunction : remap_exp
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (logic [7:0] a = 8'h00; a < 8'h18; a += 8'h04)
    begin
      apb(1'b0, a, 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("limit", cacheLimit, 1'b0);
    apb(1'b1, AUXC_OFS, 32'h40);
    chk("limit", cacheLimit, 1'b1);
    chk("limit kb", cacheLimitKb, 8'h10);
    for (int u = 0; u < 2; u++)
    begin
      acc(1'b0, 1'b0, u[0], 1'b0, 32'h8C00, 1'b0);
      acc(1'b0, 1'b1, u[0], 1'b0, 32'h8C00, 1'b1);
    end
    chk("irq masked", irq, 1'b0);
    apb(1'b0, DFAULT_OFS, 32'h0);
    chk("perm code", rd[4:0], 5'h0F);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", rd, 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status cleared", rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h2000_0000);
    apb(1'b1, MASK_OFS, 32'h3);
    acc(1'b0, 1'b0, 1'b0, 1'b0, 32'h0800, 1'b1);
    chk("irq", irq, 1'b1);
    apb(1'b0, DFAULT_OFS, 32'h0);
    chk("page flag code", rd[4:0], 5'h06);
    acc(1'b1, 1'b0, 1'b0, 1'b1, 32'h0800, 1'b1);
    apb(1'b0, IFAULT_OFS, 32'h0);
    chk("section flag code", rd[4:0], 5'h03);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", rd, 32'h3);
    chk("irq cleared", irq, 1'b0);
    acc(1'b0, 1'b1, 1'b1, 1'b0, 32'h0C00, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h0);
    acc(1'b0, 1'b1, 1'b0, 1'b0, 32'h0800, 1'b0);
    for (int n = 0; n < 12; n++)
    begin
      desc = ($random(seed) & 32'hFFFF_73FF) | 32'h4C00;
      acc(1'b0, 1'b0, desc[20], desc[21], desc, 1'b0);
      chk("type", dMemType, MT_NORMAL);
      chk("inner", dInner, desc[3:2]);
      chk("outer", dOuter, desc[13:12]);
    end
    apb(1'b1, CTRL_OFS, 32'h1000_0000);
    for (int n = 0; n < 24; n++)
    begin
      pri = $random(seed);
      nrm = $random(seed);
      desc = ($random(seed) & 32'hFFFF_73FF) | 32'h0C00;
      apb(1'b1, PRIREMAP_OFS, pri);
      apb(1'b1, NRMREMAP_OFS, nrm);
      e = remap_exp(pri, nrm, desc);
      acc(n[0], 1'b0, desc[20], desc[21], desc, 1'b0);
      chk("remap type", n[0] ? iMemType : dMemType, e[5:4]);
      if (e[5:4] == 2'b10)
      begin
        chk("remap inner", n[0] ? iInner : dInner, e[3:2]);
        chk("remap outer", n[0] ? iOuter : dOuter, e[1:0]);
      end
    end
    print_verdict();
  end
endmodule : macx_top_test
`default_nettype wire
